//--- common/trigger_info_link_defines.svh
// Constants for the trigger information uplink channel: message layout,
// stream sideband positions, buffer depths and the default chunk threshold.
// Assumes it is included by its bare name from the design files.
`ifndef TRIGGER_INFO_LINK_DEFINES_SVH
`define TRIGGER_INFO_LINK_DEFINES_SVH

`define TIL_MSG_BYTES 26
`define TIL_MSG_BITS 208
`define TIL_MSG_PAD_BITS 224
`define TIL_WORD_BITS 32
`define TIL_KEEP_BITS 4
`define TIL_USER_BITS 4
`define TIL_MSG_WORDS 7
`define TIL_LAST_WORD 3'h6
`define TIL_FULL_KEEP 4'hF
`define TIL_LAST_KEEP 4'h3
`define TIL_TRUNC_BIT 3
`define TIL_CNT_BITS 48
`define TIL_MSG_FIFO_DEPTH 16
`define TIL_OUT_FIFO_DEPTH 8
`define TIL_CHUNK_THRESHOLD_SIZE 7

`endif

//--- common/trigger_info_link_pkg.sv
// Types shared by the trigger information uplink channel.
// Assumes nothing beyond a SystemVerilog compiler.
package trigger_info_link_pkg;

  // Serialiser states: waiting for a message, or sending its words.
  typedef enum logic {
    SER_IDLE,
    SER_SEND
  } ser_state_t;

endpackage

//--- rtl/stream_fifo.sv
// Synchronous FIFO with valid and ready on both sides and a fill count.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module stream_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] wr_d;
  logic [AW-1:0] rd_q;
  logic [AW-1:0] rd_d;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic push;
  logic pop;

  // Full and empty come straight from the count, so they are never stale.
  assign in_ready_o = (count_q != CW'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem[rd_q];
  assign count_o = count_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer and count update; pointers wrap at the depth, not a power of two.
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    count_d = count_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // Storage needs no reset; only the pointers and the count define what is valid.
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
    if (reset_i) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      count_q <= count_d;
    end
  end
endmodule

//--- rtl/trigger_info_link.sv
// Trigger information uplink channel: turns each accept record that finds room in
// the message FIFO into a 26-byte message and streams it out as 32-bit words with byte enables.
// Assumes the record source sits on the same clock and pulses its ready
// input for one cycle per accept, and that the stream sink obeys tready.
`timescale 1ns/1ps
`include "trigger_info_link_defines.svh"
module trigger_info_link #(
  parameter int unsigned CHUNK_THRESHOLD_SIZE = `TIL_CHUNK_THRESHOLD_SIZE
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic [7:0] format_byte_i,
  input wire logic [7:0] length_byte_i,
  input wire logic [3:0] reserved0_i,
  input wire logic [11:0] bunch_crossing_number_i,
  input wire logic [7:0] extended_event_number_i,
  input wire logic [23:0] event_number_i,
  input wire logic [31:0] orbit_i,
  input wire logic [15:0] trigger_type_i,
  input wire logic [15:0] reserved1_i,
  input wire logic [31:0] level_zero_identifier_i,
  input wire logic record_ready_i,
  output logic [`TIL_WORD_BITS-1:0] m_axis_tdata_o,
  output logic [`TIL_KEEP_BITS-1:0] m_axis_tkeep_o,
  output logic [`TIL_USER_BITS-1:0] m_axis_tuser_o,
  output logic m_axis_tlast_o,
  output logic m_axis_tvalid_o,
  input wire logic m_axis_tready_i,
  output logic m_axis_prog_empty_o
);
  // Message FIFO entry: the padded message plus one truncation marker.
  localparam int unsigned MSG_ENTRY_BITS = `TIL_MSG_PAD_BITS + 1;
  // Output FIFO entry: data, keep, user and last.
  localparam int unsigned OUT_ENTRY_BITS =
    `TIL_WORD_BITS + `TIL_KEEP_BITS + `TIL_USER_BITS + 1;
  localparam int unsigned MSG_CW = $clog2(`TIL_MSG_FIFO_DEPTH + 1);
  localparam int unsigned OUT_CW = $clog2(`TIL_OUT_FIFO_DEPTH + 1);

  // ------------------------------------------------------------------
  // Input register stage.
  // ------------------------------------------------------------------
  logic enable_q;
  logic enable_d;
  logic ready_q;
  logic ready_d;
  logic [7:0] format_q;
  logic [7:0] format_d;
  logic [7:0] length_q;
  logic [7:0] length_d;
  logic [3:0] res0_q;
  logic [3:0] res0_d;
  logic [11:0] bcn_q;
  logic [11:0] bcn_d;
  logic [7:0] xevt_q;
  logic [7:0] xevt_d;
  logic [23:0] evt_q;
  logic [23:0] evt_d;
  logic [31:0] orbit_q;
  logic [31:0] orbit_d;
  logic [15:0] ttype_q;
  logic [15:0] ttype_d;
  logic [15:0] res1_q;
  logic [15:0] res1_d;
  logic [31:0] level_zero_identifier_q;
  logic [31:0] level_zero_identifier_d;

  // Every record field and the enable pass one register before use, so the
  // message is built from a stable copy taken on the trigger cycle.
  always_comb begin
    enable_d = enable_i;
    ready_d = record_ready_i;
    format_d = format_byte_i;
    length_d = length_byte_i;
    res0_d = reserved0_i;
    bcn_d = bunch_crossing_number_i;
    xevt_d = extended_event_number_i;
    evt_d = event_number_i;
    orbit_d = orbit_i;
    ttype_d = trigger_type_i;
    res1_d = reserved1_i;
    level_zero_identifier_d = level_zero_identifier_i;
  end

  // Only the control bits need a reset value; the fields are qualified
  // by the ready bit.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      enable_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      ready_q <= ready_d;
    end
    format_q <= format_d;
    length_q <= length_d;
    res0_q <= res0_d;
    bcn_q <= bcn_d;
    xevt_q <= xevt_d;
    evt_q <= evt_d;
    orbit_q <= orbit_d;
    ttype_q <= ttype_d;
    res1_q <= res1_d;
    level_zero_identifier_q <= level_zero_identifier_d;
  end

  // ------------------------------------------------------------------
  // Trigger, accept counter and message assembly.
  // ------------------------------------------------------------------
  logic trigger;
  logic [`TIL_CNT_BITS-1:0] accept_cnt_q;
  logic [`TIL_CNT_BITS-1:0] accept_cnt_d;
  logic trunc_pend_q;
  logic trunc_pend_d;
  logic [`TIL_MSG_BITS-1:0] msg_be;
  logic [`TIL_MSG_PAD_BITS-1:0] msg_pad;
  logic [MSG_ENTRY_BITS-1:0] msg_entry;
  logic msg_in_ready;
  logic msg_out_valid;
  logic msg_out_ready;
  logic [MSG_ENTRY_BITS-1:0] msg_out_data;

  // A ready pulse is a trigger only while the channel is enabled; the
  // source pulses once per accept, so each high cycle is one event.
  assign trigger = ready_q && enable_q;

  // Fields in wire order, most significant byte of each field first.
  // There is no event counter reset input of its own; the counter clears
  // only with reset_i, so it counts every trigger since the last reset.
  assign msg_be = {format_q, length_q,
                   res0_q, bcn_q,
                   xevt_q, evt_q,
                   orbit_q,
                   ttype_q, res1_q,
                   level_zero_identifier_q,
                   accept_cnt_q};

  // Byte k of the message goes to bits 8k+7..8k, so the lowest byte lands
  // in the least significant lane; the padding bytes are zero.
  always_comb begin
    msg_pad = '0;
    for (int k = 0; k < `TIL_MSG_BYTES; k++) begin
      msg_pad[8*k +: 8] = msg_be[`TIL_MSG_BITS-1-8*k -: 8];
    end
  end

  // The marker tells the consumer that one or more events before this
  // message were dropped.
  assign msg_entry = {trunc_pend_q, msg_pad};

  // Every trigger counts, dropped or not, so a gap in the counter shows
  // the loss. A drop arms the marker; the next stored message carries it.
  // A drop and a store never share a cycle, so no set/clear race exists.
  always_comb begin
    accept_cnt_d = accept_cnt_q;
    trunc_pend_d = trunc_pend_q;
    if (trigger) begin
      accept_cnt_d = accept_cnt_q + 1'b1;
      if (msg_in_ready) begin
        trunc_pend_d = 1'b0;
      end else begin
        trunc_pend_d = 1'b1;
      end
    end
  end

  // Counter and marker registers.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      accept_cnt_q <= '0;
      trunc_pend_q <= 1'b0;
    end else begin
      accept_cnt_q <= accept_cnt_d;
      trunc_pend_q <= trunc_pend_d;
    end
  end

  // Whole messages are stored in one write, which is what lets a trigger
  // be taken on every cycle until sixteen are waiting.
  stream_fifo #(
    .WIDTH(MSG_ENTRY_BITS),
    .DEPTH(`TIL_MSG_FIFO_DEPTH)
  ) u_msg_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_valid_i(trigger),
    .in_ready_o(msg_in_ready),
    .in_data_i(msg_entry),
    .out_valid_o(msg_out_valid),
    .out_ready_i(msg_out_ready),
    .out_data_o(msg_out_data),
    .count_o()
  );

  // ------------------------------------------------------------------
  // Serialiser: one message into seven stream words.
  // ------------------------------------------------------------------
  trigger_info_link_pkg::ser_state_t ser_state_q;
  trigger_info_link_pkg::ser_state_t ser_state_d;
  logic [2:0] word_q;
  logic [2:0] word_d;
  logic [MSG_ENTRY_BITS-1:0] cur_q;
  logic [MSG_ENTRY_BITS-1:0] cur_d;
  logic ser_valid;
  logic ser_ready;
  logic ser_last;
  logic [`TIL_WORD_BITS-1:0] ser_data;
  logic [`TIL_KEEP_BITS-1:0] ser_keep;
  logic [`TIL_USER_BITS-1:0] ser_user;
  logic [OUT_ENTRY_BITS-1:0] ser_entry;

  // Word fields; the last word holds bytes 24 and 25 only.
  always_comb begin
    ser_valid = (ser_state_q == trigger_info_link_pkg::SER_SEND);
    ser_last = (word_q == `TIL_LAST_WORD);
    ser_data = cur_q[`TIL_WORD_BITS*word_q +: `TIL_WORD_BITS];
    ser_keep = ser_last ? `TIL_LAST_KEEP : `TIL_FULL_KEEP;
    ser_user = '0;
    ser_user[`TIL_TRUNC_BIT] = cur_q[MSG_ENTRY_BITS-1];
  end

  assign ser_entry = {ser_data, ser_keep, ser_user, ser_last};

  // Next message is fetched while the last word leaves, so messages flow
  // back to back when the output side keeps up.
  always_comb begin
    ser_state_d = ser_state_q;
    word_d = word_q;
    cur_d = cur_q;
    msg_out_ready = 1'b0;
    case (ser_state_q)
      trigger_info_link_pkg::SER_IDLE: begin
        if (msg_out_valid) begin
          msg_out_ready = 1'b1;
          cur_d = msg_out_data;
          word_d = '0;
          ser_state_d = trigger_info_link_pkg::SER_SEND;
        end
      end
      trigger_info_link_pkg::SER_SEND: begin
        if (ser_ready) begin
          if (ser_last) begin
            word_d = '0;
            if (msg_out_valid) begin
              msg_out_ready = 1'b1;
              cur_d = msg_out_data;
            end else begin
              ser_state_d = trigger_info_link_pkg::SER_IDLE;
            end
          end else begin
            word_d = word_q + 1'b1;
          end
        end
      end
      default: begin
        ser_state_d = trigger_info_link_pkg::SER_IDLE;
        word_d = '0;
      end
    endcase
  end

  // Serialiser registers.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ser_state_q <= trigger_info_link_pkg::SER_IDLE;
      word_q <= '0;
      cur_q <= '0;
    end else begin
      ser_state_q <= ser_state_d;
      word_q <= word_d;
      cur_q <= cur_d;
    end
  end

  // ------------------------------------------------------------------
  // Output FIFO and registered stream port.
  // ------------------------------------------------------------------
  logic out_fifo_valid;
  logic out_fifo_ready;
  logic [OUT_ENTRY_BITS-1:0] out_fifo_data;
  logic [OUT_CW-1:0] out_fifo_count;

  // A stalled sink fills this FIFO, which stalls the serialiser, which in
  // turn backs up the message FIFO until triggers are dropped.
  stream_fifo #(
    .WIDTH(OUT_ENTRY_BITS),
    .DEPTH(`TIL_OUT_FIFO_DEPTH)
  ) u_out_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_valid_i(ser_valid),
    .in_ready_o(ser_ready),
    .in_data_i(ser_entry),
    .out_valid_o(out_fifo_valid),
    .out_ready_i(out_fifo_ready),
    .out_data_o(out_fifo_data),
    .count_o(out_fifo_count)
  );

  logic tvalid_q;
  logic tvalid_d;
  logic [`TIL_WORD_BITS-1:0] tdata_q;
  logic [`TIL_WORD_BITS-1:0] tdata_d;
  logic [`TIL_KEEP_BITS-1:0] tkeep_q;
  logic [`TIL_KEEP_BITS-1:0] tkeep_d;
  logic [`TIL_USER_BITS-1:0] tuser_q;
  logic [`TIL_USER_BITS-1:0] tuser_d;
  logic tlast_q;
  logic tlast_d;
  logic prog_empty_q;
  logic prog_empty_d;
  logic [OUT_CW:0] buffered;

  // The port register refills whenever it is empty or being taken, so a
  // steady tready gives one word per cycle.
  assign out_fifo_ready = !tvalid_q || m_axis_tready_i;

  // Stream holds its word stable while tvalid is high and tready low.
  always_comb begin
    tvalid_d = tvalid_q;
    tdata_d = tdata_q;
    tkeep_d = tkeep_q;
    tuser_d = tuser_q;
    tlast_d = tlast_q;
    if (out_fifo_ready) begin
      tvalid_d = out_fifo_valid;
      if (out_fifo_valid) begin
        {tdata_d, tkeep_d, tuser_d, tlast_d} = out_fifo_data;
      end
    end
  end

  // Words held in the FIFO plus the one on the port; the flag drops once
  // a full chunk is waiting.
  assign buffered = {1'b0, out_fifo_count} + {{OUT_CW{1'b0}}, tvalid_q};
  assign prog_empty_d = (32'(buffered) < CHUNK_THRESHOLD_SIZE);

  // Port registers; outputs come straight from these.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tvalid_q <= 1'b0;
      tdata_q <= '0;
      tkeep_q <= '0;
      tuser_q <= '0;
      tlast_q <= 1'b0;
      prog_empty_q <= 1'b1;
    end else begin
      tvalid_q <= tvalid_d;
      tdata_q <= tdata_d;
      tkeep_q <= tkeep_d;
      tuser_q <= tuser_d;
      tlast_q <= tlast_d;
      prog_empty_q <= prog_empty_d;
    end
  end

  // Stream side shares the single system clock and reset.
  assign m_axis_tvalid_o = tvalid_q;
  assign m_axis_tdata_o = tdata_q;
  assign m_axis_tkeep_o = tkeep_q;
  assign m_axis_tuser_o = tuser_q;
  assign m_axis_tlast_o = tlast_q;
  assign m_axis_prog_empty_o = prog_empty_q;
endmodule

//--- tb/stream_sink_model.sv
// Behavioural model of the router's auxiliary stream input.
// Assumes the channel's clock and synchronous reset; mode 0 full rate, 1 slow, 2 stopped.
`timescale 1ns/1ps
module stream_sink_model (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [1:0] mode_i,
  output logic tready_o
);
  logic [1:0] phase_q;
  // A registered ready that is high on one cycle in every four when slow.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      phase_q <= 2'h0;
      tready_o <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      tready_o <= (mode_i == 2'h0) || (mode_i == 2'h1 && phase_q == 2'h3);
    end
  end
endmodule

//--- tb/trigger_info_link_checker.sv
// Checker for the trigger information uplink: stream framing, hold and start-up timing.
// Sees only the ports of the channel's top module and is bound to it below.
`timescale 1ns/1ps
module trigger_info_link_checker #(
  parameter int unsigned CHUNK_THRESHOLD_SIZE = 7
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic record_ready_i,
  input wire logic [31:0] m_axis_tdata_o,
  input wire logic [3:0] m_axis_tkeep_o,
  input wire logic [3:0] m_axis_tuser_o,
  input wire logic m_axis_tlast_o,
  input wire logic m_axis_tvalid_o,
  input wire logic m_axis_tready_i,
  input wire logic m_axis_prog_empty_o
);
  logic take;
  logic [2:0] wcnt_q, wcnt_d;
  logic trunc_q, trunc_d;
  logic [3:0] quiet_q, quiet_d;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  assign take = m_axis_tvalid_o && m_axis_tready_i;
  // Word position, first-word flag, and idle time since the last accepted pulse.
  always_comb begin
    wcnt_d = wcnt_q;
    trunc_d = trunc_q;
    quiet_d = (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
    if (take) begin
      wcnt_d = m_axis_tlast_o ? 3'h0 : wcnt_q + 3'h1;
      if (wcnt_q == 3'h0) trunc_d = m_axis_tuser_o[3];
    end
    if (record_ready_i && enable_i) quiet_d = 4'h0;
  end
  // Helper state only; fifteen quiet cycles with no valid means an empty pipeline.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wcnt_q <= 3'h0;
      trunc_q <= 1'b0;
      quiet_q <= 4'h0;
    end else begin
      wcnt_q <= wcnt_d;
      trunc_q <= trunc_d;
      quiet_q <= quiet_d;
    end
  end
  property p_keep_full;
    m_axis_tvalid_o && !m_axis_tlast_o |-> m_axis_tkeep_o == 4'hF && wcnt_q < 3'h6;
  endproperty
  a_keep_full: assert property (p_keep_full) else $error("inner word framing wrong");
  property p_keep_last;
    m_axis_tvalid_o && m_axis_tlast_o |-> m_axis_tkeep_o == 4'h3 && m_axis_tdata_o[31:16] == 16'h0;
  endproperty
  a_keep_last: assert property (p_keep_last) else $error("last word lanes wrong");
  property p_len;
    m_axis_tvalid_o && m_axis_tlast_o |-> wcnt_q == 3'h6;
  endproperty
  a_len: assert property (p_len) else $error("message not seven words");
  property p_hold;
    m_axis_tvalid_o && !m_axis_tready_i |=> m_axis_tvalid_o &&
      $stable({m_axis_tdata_o, m_axis_tkeep_o, m_axis_tuser_o, m_axis_tlast_o});
  endproperty
  a_hold: assert property (p_hold) else $error("stream word changed while stalled");
  property p_user_low;
    m_axis_tvalid_o |-> m_axis_tuser_o[2:0] == 3'h0;
  endproperty
  a_user_low: assert property (p_user_low) else $error("unused user bits set");
  property p_trunc;
    m_axis_tvalid_o && wcnt_q != 3'h0 |-> m_axis_tuser_o[3] == trunc_q;
  endproperty
  a_trunc: assert property (p_trunc) else $error("truncation flag changed in message");
  property p_start;
    quiet_q == 4'hF && !m_axis_tvalid_o && record_ready_i && enable_i
      |=> !m_axis_tvalid_o [*3] ##[1:4] m_axis_tvalid_o;
  endproperty
  a_start: assert property (p_start) else $error("pulse did not start a message");
  property p_ignore;
    quiet_q == 4'hF && !m_axis_tvalid_o && record_ready_i && !enable_i
      |=> !m_axis_tvalid_o [*8];
  endproperty
  a_ignore: assert property (p_ignore) else $error("disabled pulse made output");
  property p_reset;
    disable iff (1'b0) reset_i |=> !m_axis_tvalid_o && m_axis_prog_empty_o;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not idle after reset");
  // A chunk counted as buffered must already be offered on the port.
  property p_prog;
    !m_axis_prog_empty_o && CHUNK_THRESHOLD_SIZE > 0 |-> m_axis_tvalid_o;
  endproperty
  a_prog: assert property (p_prog) else $error("chunk flag low with nothing offered");
  c_last: cover property (take && m_axis_tlast_o);
  c_trunc: cover property (m_axis_tvalid_o && m_axis_tuser_o[3]);
  c_b2b: cover property (record_ready_i && $past(record_ready_i));
endmodule

bind trigger_info_link trigger_info_link_checker #(
  .CHUNK_THRESHOLD_SIZE(CHUNK_THRESHOLD_SIZE)
) u_trigger_info_link_checker (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .enable_i(enable_i),
  .record_ready_i(record_ready_i), .m_axis_tdata_o(m_axis_tdata_o),
  .m_axis_tkeep_o(m_axis_tkeep_o), .m_axis_tuser_o(m_axis_tuser_o),
  .m_axis_tlast_o(m_axis_tlast_o), .m_axis_tvalid_o(m_axis_tvalid_o),
  .m_axis_tready_i(m_axis_tready_i), .m_axis_prog_empty_o(m_axis_prog_empty_o)
);

//--- tb/trigger_info_link_tb.sv
// Self-checking bench for the trigger information uplink channel.
// Assumes the channel, its checker and the stream sink model are compiled first.
`timescale 1ns/1ps
module trigger_info_link_tb;
  logic clk, rst, enable, record_ready, tready, tlast, tvalid, prog_empty;
  logic [7:0] format_byte, length_byte, extended_event_number;
  logic [3:0] reserved0, tkeep, tuser;
  logic [11:0] bunch_crossing_number;
  logic [23:0] event_number;
  logic [31:0] orbit, level_zero_identifier, tdata;
  logic [15:0] trigger_type, reserved1;
  logic [1:0] sink_mode;
  logic [47:0] exp_cnt;
  int err_count, n_tests, cycles;
  trigger_info_link u_trigger_info_link (
    .sys_clk_i(clk), .reset_i(rst), .enable_i(enable), .format_byte_i(format_byte),
    .length_byte_i(length_byte), .reserved0_i(reserved0),
    .bunch_crossing_number_i(bunch_crossing_number),
    .extended_event_number_i(extended_event_number), .event_number_i(event_number),
    .orbit_i(orbit), .trigger_type_i(trigger_type), .reserved1_i(reserved1),
    .level_zero_identifier_i(level_zero_identifier), .record_ready_i(record_ready),
    .m_axis_tdata_o(tdata), .m_axis_tkeep_o(tkeep), .m_axis_tuser_o(tuser),
    .m_axis_tlast_o(tlast), .m_axis_tvalid_o(tvalid), .m_axis_tready_i(tready),
    .m_axis_prog_empty_o(prog_empty)
  );
  stream_sink_model u_stream_sink_model (
    .sys_clk_i(clk), .reset_i(rst), .mode_i(sink_mode), .tready_o(tready)
  );
  // Message contents depend only on the counter carried, so any message is judged alone.
  function automatic logic [207:0] msg(input logic [47:0] c);
    msg = {8'hA5 ^ c[7:0], 8'h1A, 4'h5, 12'h300 + c[11:0], 8'h0C, c[23:0],
      32'h0ABC0000 + c[31:0], 16'h1234 ^ c[15:0], 16'h00F0, 32'hC0DE0000 + c[31:0], c};
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("tests=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Ready pulses on n consecutive cycles; the event number tracks the counter.
  task automatic pulse(input int n);
    logic [207:0] m;
    for (int j = 0; j < n; j++) begin
      m = msg(exp_cnt);
      {format_byte, length_byte, reserved0, bunch_crossing_number, extended_event_number,
        event_number, orbit, trigger_type, reserved1, level_zero_identifier} = m[207:48];
      record_ready = 1'b1;
      if (enable) exp_cnt++;
      @(negedge clk);
    end
    record_ready = 1'b0;
    @(negedge clk);
  endtask
  // Takes one whole message; a transfer seen at a falling edge completes at the next rise.
  task automatic recv(output logic [47:0] c, output logic tr, output logic got);
    logic [31:0] w [7];
    logic [4:0] kl [7];
    logic [207:0] m;
    logic [7:0] e;
    int t;
    got = 1'b0;
    tr = 1'b0;
    c = 48'h0;
    for (int i = 0; i < 7; i++) begin
      t = 0;
      while (!(tvalid === 1'b1 && tready === 1'b1) && t < 80) begin
        @(negedge clk);
        t++;
      end
      if (t == 80) begin
        if (i != 0) check(64'(i), 64'h7);
        return;
      end
      w[i] = tdata;
      kl[i] = {tkeep, tlast};
      if (i == 0) tr = tuser[3];
      @(negedge clk);
    end
    got = 1'b1;
    c = {w[5][7:0], w[5][15:8], w[5][23:16], w[5][31:24], w[6][7:0], w[6][15:8]};
    m = msg(c);
    for (int i = 0; i < 7; i++) begin
      for (int b = 0; b < 4; b++) begin
        e = (4*i+b < 26) ? m[207-8*(4*i+b) -: 8] : 8'h00;
        check(64'(w[i][8*b +: 8]), 64'(e));
      end
      check(64'(kl[i]), 64'((i == 6) ? 5'h07 : 5'h1E));
    end
  endtask
  task automatic t_single();
    logic [47:0] c;
    logic tr, got;
    pulse(1);
    recv(c, tr, got);
    check(64'(got), 64'h1);
    check(64'(c), 64'(exp_cnt - 48'h1));
    check(64'(tr), 64'h0);
  endtask
  task automatic t_b2b();
    logic [47:0] c;
    logic tr, got;
    sink_mode = 2'h1;
    pulse(4);
    for (int i = 4; i > 0; i--) begin
      recv(c, tr, got);
      check(64'(c), 64'(exp_cnt - 48'(i)));
      check(64'({got, tr}), 64'h2);
    end
    sink_mode = 2'h0;
  endtask
  task automatic t_disable();
    repeat (20) @(negedge clk);
    enable = 1'b0;
    pulse(3);
    repeat (20) @(negedge clk);
    check(64'(tvalid), 64'h0);
    enable = 1'b1;
    repeat (20) @(negedge clk);
    t_single();
  endtask
  task automatic t_prog();
    logic [47:0] c;
    logic tr, got;
    sink_mode = 2'h2;
    repeat (20) @(negedge clk);
    check(64'(prog_empty), 64'h1);
    pulse(1);
    repeat (20) @(negedge clk);
    check(64'(prog_empty), 64'h0);
    sink_mode = 2'h0;
    recv(c, tr, got);
    repeat (5) @(negedge clk);
    check(64'({got, prog_empty}), 64'h3);
  endtask
  task automatic t_over();
    logic [47:0] c, prev;
    logic tr, got;
    int n;
    sink_mode = 2'h2;
    pulse(30);
    prev = exp_cnt - 48'd31;
    n = 0;
    sink_mode = 2'h0;
    got = 1'b1;
    while (got) begin
      recv(c, tr, got);
      if (got) begin
        check(64'({c, tr}), 64'({prev + 48'h1, 1'b0}));
        prev = c;
        n++;
      end
    end
    check(64'(n >= 16 && n < 30), 64'h1);
    pulse(1);
    recv(c, tr, got);
    check(64'({c, tr}), 64'({exp_cnt - 48'h1, 1'b1}));
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Cuts a hang short well beyond the several hundred cycles the scenarios need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    enable = 1'b1;
    record_ready = 1'b0;
    sink_mode = 2'h0;
    exp_cnt = 48'h0;
    {format_byte, length_byte, reserved0, bunch_crossing_number, extended_event_number,
      event_number, orbit, trigger_type, reserved1, level_zero_identifier} = 160'h0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (20) @(negedge clk);
    t_single();
    t_b2b();
    t_disable();
    t_prog();
    t_over();
    close_out();
  end
endmodule
